/* File: rtl/gpio_pkg.sv */
/*
  Constants for the 32-pin I/O port: register offsets, setup word field
  positions, encodings and reset values.
  Assumes a 12-bit byte address on the register port.
*/
package gpio_pkg;
  localparam int          NUM_PINS   = 32;
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 32;
  localparam int          DRV_W      = 3;
  // register byte offsets
  localparam logic [11:0] OFS_DRIVE_LEVEL  = 12'h504;
  localparam logic [11:0] OFS_DRIVE_SET    = 12'h508;
  localparam logic [11:0] OFS_DRIVE_CLR    = 12'h50c;
  localparam logic [11:0] OFS_PIN_LEVEL    = 12'h510;
  localparam logic [11:0] OFS_OE_MASK      = 12'h514;
  localparam logic [11:0] OFS_OE_SET       = 12'h518;
  localparam logic [11:0] OFS_OE_CLR       = 12'h51c;
  localparam logic [11:0] OFS_SETUP_FIRST  = 12'h700;
  localparam logic [11:0] OFS_SETUP_LAST   = 12'h77c;
  // setup word field positions
  localparam int          F_DIR      = 0;
  localparam int          F_INPUT    = 1;
  localparam int          F_PULL_LO  = 2;
  localparam int          F_DRIVE_LO = 8;
  localparam int          F_SENSE_LO = 16;
  // writable bits of a setup word other than direction
  localparam logic [31:0] SETUP_WMASK = 32'h0003_070e;
  // field encodings
  localparam logic [1:0]  PULL_DOWN  = 2'h1;
  localparam logic [1:0]  PULL_UP    = 2'h3;
  localparam logic [1:0]  SENSE_HIGH = 2'h2;
  localparam logic [1:0]  SENSE_LOW  = 2'h3;
  // reset values
  localparam logic [31:0] SETUP_RST  = 32'h0000_0002;
  localparam logic [31:0] DRIVE_RST  = 32'h0000_0000;
  localparam logic [31:0] OE_RST     = 32'h0000_0000;
  // pins wired to the analog tap
  localparam logic [31:0] ANALOG_CAPABLE = 32'h0000_00ff;
endpackage : gpio_pkg

/* File: rtl/setup_if.sv */
/*
  Carrier between the port logic and the setup word store.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface setup_if;
  import gpio_pkg::*;
  logic                               wr_en;
  logic [4:0]                         wr_idx;
  logic [31:0]                        wr_data;
  logic [NUM_PINS-1:0][DATA_W-1:0]    words;
  modport store (input wr_en, input wr_idx, input wr_data, output words);
  modport ctrl  (output wr_en, output wr_idx, output wr_data, input words);
endinterface : setup_if

/* File: rtl/pin_sync.sv */
/*
  Two-stage synchroniser for the pin inputs.
  Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // data
  input  wire logic [31:0]   d,
  output logic      [31:0]   q
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [31:0] s1;
    logic [31:0] s2;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : pin_sync

/* File: rtl/setup_store.sv */
/*
  Retained store of the 32 per-pin setup words (direction bit excluded).
  Assumes writes arrive already masked; nothing but reset clears it.
*/
`timescale 1ns/1ps
module setup_store (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // store port
  setup_if.store    sb
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [NUM_PINS-1:0][DATA_W-1:0] w;
  } store_s;

  store_s st_r;
  store_s st_nxt;

  // power mode changes never touch the words, only reset does
  always_comb begin
    st_nxt = st_r;
    if (sb.wr_en) begin
      st_nxt.w[sb.wr_idx] = sb.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= {NUM_PINS{SETUP_RST}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sb.words = st_r.w;
endmodule : setup_store

/* File: rtl/gpio_port.sv */
/*
  32-pin general-purpose I/O port with per-pin setup words, level sense
  and a shared detect line; registers on a plain strobe port.
  Assumes a single clock, pins asynchronous, peripheral requests on clk.
*/
// Our own choice: the plain strobed port.
// Function
// - port of 32 pins, each with a setup word indexed by pin
// - setup word selects direction, drive, pulls, sense and input buffer
// - setup words are retained across power mode changes
// - sensing enabled and chosen level present raises the shared detect line
// - sense and detect keep working in both ON and OFF modes
// - each pin's input buffer can be disconnected to save power
// - input level and sense see pin data only while buffer connected
// - peripherals can take over output level and direction, and read inputs
// - direction register and setup direction bits are one shared state
// - write to drive set alias sets chosen bits, others unchanged
// - write to drive clear alias clears chosen bits, others unchanged
// - direction register holds one bit per pin, with set and clear aliases
// - setup words sit at consecutive words, pin 0 to pin 31
`timescale 1ns/1ps
module gpio_port (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset,
  // register port
  input  wire logic [gpio_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [gpio_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [gpio_pkg::DATA_W-1:0]   reg_rdata,
  // power state
  input  wire logic                          power_off,
  // pins
  input  wire logic [gpio_pkg::NUM_PINS-1:0] pin_in,
  output logic      [gpio_pkg::NUM_PINS-1:0] pin_out,
  output logic      [gpio_pkg::NUM_PINS-1:0] pin_oe_n,
  output logic      [gpio_pkg::NUM_PINS-1:0] pin_pull_up,
  output logic      [gpio_pkg::NUM_PINS-1:0] pin_pull_down,
  output logic      [gpio_pkg::NUM_PINS*gpio_pkg::DRV_W-1:0] pin_drive,
  // peripheral takeover
  input  wire logic [gpio_pkg::NUM_PINS-1:0] periph_own,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] periph_out,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] periph_oe,
  input  wire logic [gpio_pkg::NUM_PINS-1:0] periph_analog_req,
  output logic      [gpio_pkg::NUM_PINS-1:0] periph_in,
  output logic      [gpio_pkg::NUM_PINS-1:0] analog_pin_tap,
  // shared detect line
  output logic                               detect
);
  import gpio_pkg::*;

  typedef struct packed {
    logic [NUM_PINS-1:0]       drive_lvl;
    logic [NUM_PINS-1:0]       dir;
    logic [DATA_W-1:0]         rdata;
    logic [NUM_PINS-1:0]       out;
    logic [NUM_PINS-1:0]       oe_n;
    logic [NUM_PINS-1:0]       pu;
    logic [NUM_PINS-1:0]       pd;
    logic [NUM_PINS*DRV_W-1:0] drv;
    logic [NUM_PINS-1:0]       ana;
    logic [NUM_PINS-1:0]       lvl;
    logic                      det;
  } port_s;

  port_s               st_r;
  port_s               st_nxt;

  setup_if             sb ();
  logic [NUM_PINS-1:0] pin_sync_q;
  logic [NUM_PINS-1:0] conn;
  logic [NUM_PINS-1:0] lvl_now;
  logic [NUM_PINS-1:0] sense_hit;
  logic [NUM_PINS-1:0] pu_cfg;
  logic [NUM_PINS-1:0] pd_cfg;
  logic [NUM_PINS*DRV_W-1:0] drv_cfg;
  logic                in_setup;
  logic [4:0]          setup_idx;
  logic                wr_ok;

  // pins are asynchronous, so two flops before anything looks at them
  pin_sync u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (pin_in),
    .q     (pin_sync_q)
  );

  // retained words hold everything but the direction bit
  setup_store u_store (
    .clk   (clk),
    .reset (reset),
    .sb    (sb)
  );

  // setup words occupy one aligned word per pin
  assign in_setup  = (reg_addr >= OFS_SETUP_FIRST) && (reg_addr <= OFS_SETUP_LAST)
                     && (reg_addr[1:0] == 2'h0);
  assign setup_idx = reg_addr[6:2];

  // the cpu is halted in OFF mode, so register writes only land in ON
  assign wr_ok = reg_wr && !power_off;

  // store write path; direction bit is kept in the port vector instead
  assign sb.wr_en   = wr_ok && in_setup;
  assign sb.wr_idx  = setup_idx;
  assign sb.wr_data = reg_wdata & SETUP_WMASK;

  // per-pin decode of the setup words
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    // buffer connect bit clear means connected
    assign conn[i]    = ~sb.words[i][F_INPUT];
    // disconnected buffers read as low and cannot trigger sense
    assign lvl_now[i] = conn[i] & pin_sync_q[i];
    assign sense_hit[i] = conn[i] &
      (((sb.words[i][F_SENSE_LO +: 2] == SENSE_HIGH) & pin_sync_q[i]) |
       ((sb.words[i][F_SENSE_LO +: 2] == SENSE_LOW) & ~pin_sync_q[i]));
    assign pu_cfg[i]  = (sb.words[i][F_PULL_LO +: 2] == PULL_UP);
    assign pd_cfg[i]  = (sb.words[i][F_PULL_LO +: 2] == PULL_DOWN);
    assign drv_cfg[i*DRV_W +: DRV_W] = sb.words[i][F_DRIVE_LO +: DRV_W];
  end

  // next state of the whole port
  always_comb begin
    st_nxt = st_r;

    // register writes
    if (wr_ok) begin
      case (reg_addr)
        OFS_DRIVE_LEVEL: begin
          st_nxt.drive_lvl = reg_wdata;
        end
        OFS_DRIVE_SET: begin
          st_nxt.drive_lvl = st_r.drive_lvl | reg_wdata;
        end
        OFS_DRIVE_CLR: begin
          st_nxt.drive_lvl = st_r.drive_lvl & ~reg_wdata;
        end
        OFS_OE_MASK: begin
          st_nxt.dir = reg_wdata;
        end
        OFS_OE_SET: begin
          st_nxt.dir = st_r.dir | reg_wdata;
        end
        OFS_OE_CLR: begin
          st_nxt.dir = st_r.dir & ~reg_wdata;
        end
        default: begin
          // one direction state serves both views
          if (in_setup) begin
            st_nxt.dir[setup_idx] = reg_wdata[F_DIR];
          end
        end
      endcase
    end

    // read data stand for one cycle only, zero otherwise
    st_nxt.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_DRIVE_LEVEL,
        OFS_DRIVE_SET,
        OFS_DRIVE_CLR: begin
          st_nxt.rdata = st_r.drive_lvl;
        end
        OFS_PIN_LEVEL: begin
          st_nxt.rdata = lvl_now;
        end
        OFS_OE_MASK,
        OFS_OE_SET,
        OFS_OE_CLR: begin
          st_nxt.rdata = st_r.dir;
        end
        default: begin
          if (in_setup) begin
            st_nxt.rdata = sb.words[setup_idx] |
                           {31'h0000_0000, st_r.dir[setup_idx]};
          end
        end
      endcase
    end

    // pin drive: an owning peripheral replaces level and direction
    st_nxt.out  = (periph_own & periph_out) | (~periph_own & st_r.drive_lvl);
    st_nxt.oe_n = ~((periph_own & periph_oe) | (~periph_own & st_r.dir));
    st_nxt.pu   = pu_cfg;
    st_nxt.pd   = pd_cfg;
    st_nxt.drv  = drv_cfg;

    // only wired pins can reach the analog tap
    st_nxt.ana  = periph_analog_req & ANALOG_CAPABLE;
    st_nxt.lvl  = lvl_now;

    // no power gating here, so detect runs in OFF mode too
    st_nxt.det  = |sense_hit;
  end

  // system reset only; the power mode input never clears state
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r           <= '0;
      st_r.drive_lvl <= DRIVE_RST;
      st_r.dir       <= OE_RST;
      st_r.oe_n      <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // all outputs straight from the state flops
  assign reg_rdata      = st_r.rdata;
  assign pin_out        = st_r.out;
  assign pin_oe_n       = st_r.oe_n;
  assign pin_pull_up    = st_r.pu;
  assign pin_pull_down  = st_r.pd;
  assign pin_drive      = st_r.drv;
  assign periph_in      = st_r.lvl;
  assign analog_pin_tap = st_r.ana;
  assign detect         = st_r.det;
endmodule : gpio_port

/* File: verification/gpio_port_assertions.sv */
/* checker on the gpio_port ports: register writes, aliases, takeover, analog tap.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module gpio_port_assertions
  import gpio_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        power_off,
  // pins and peripherals
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] periph_own,
  input wire logic [31:0] periph_out,
  input wire logic [31:0] periph_analog_req,
  input wire logic [31:0] analog_pin_tap
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a write counts only when taken, not in OFF mode, and left alone for one cycle
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped; reg_rd && reg_addr == 12'h600 |=> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
  property p_analog; 1 |=> analog_pin_tap == ($past(periph_analog_req) & ANALOG_CAPABLE); endproperty
  a_analog: assert property (p_analog) else $error("analog tap wrong");
  property p_own_out; 1 |=> ((pin_out ^ $past(periph_out)) & $past(periph_own)) == 32'h0; endproperty
  a_own_out: assert property (p_own_out) else $error("takeover level lost");
  property p_drv_set;
    reg_wr && reg_addr == OFS_DRIVE_SET && !power_off ##1 !reg_wr && periph_own == 32'h0
      |=> (pin_out & $past(reg_wdata, 2)) == $past(reg_wdata, 2);
  endproperty
  a_drv_set: assert property (p_drv_set) else $error("set alias missed");
  property p_drv_clr;
    reg_wr && reg_addr == OFS_DRIVE_CLR && !power_off ##1 !reg_wr && periph_own == 32'h0
      |=> (pin_out & $past(reg_wdata, 2)) == 32'h0;
  endproperty
  a_drv_clr: assert property (p_drv_clr) else $error("clear alias missed");
  property p_drv_all;
    reg_wr && reg_addr == OFS_DRIVE_LEVEL && !power_off ##1 !reg_wr && periph_own == 32'h0
      |=> pin_out == $past(reg_wdata, 2);
  endproperty
  a_drv_all: assert property (p_drv_all) else $error("level load missed");
  property p_oe_set;
    reg_wr && reg_addr == OFS_OE_SET && !power_off ##1 !reg_wr && periph_own == 32'h0
      |=> (pin_oe_n & $past(reg_wdata, 2)) == 32'h0;
  endproperty
  a_oe_set: assert property (p_oe_set) else $error("direction set missed");
  property p_oe_clr;
    reg_wr && reg_addr == OFS_OE_CLR && !power_off ##1 !reg_wr && periph_own == 32'h0
      |=> (pin_oe_n & $past(reg_wdata, 2)) == $past(reg_wdata, 2);
  endproperty
  a_oe_clr: assert property (p_oe_clr) else $error("direction clear missed");
endmodule : gpio_port_assertions

bind gpio_port gpio_port_assertions chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .power_off(power_off), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_own(periph_own),
  .periph_out(periph_out), .periph_analog_req(periph_analog_req),
  .analog_pin_tap(analog_pin_tap));

/* File: verification/pin_world.sv */
/* external circuitry on the 32 pins.
   assumes the bench chooses which pins it drives and to what level. */
`timescale 1ns/1ps
module pin_world (
  // clock
  input wire logic        clk,
  // port side
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] pin_pull_up,
  input wire logic [31:0] pin_pull_down,
  output logic     [31:0] pin_in,
  // outside sources
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_en
);
  logic [31:0] wig_r = 32'h5555_aaaa;
  // a floating pin wanders, so a stale value never passes for a real one
  always @(posedge clk) wig_r <= ~wig_r;
  // own drive wins, then outside source, then pulls
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pin_pull_up | (~pin_pull_down & wig_r)));
endmodule : pin_world

/* File: verification/gpio_port_with_pin_sense_test.sv */
/* self-checking bench for gpio_port with a pin-side model.
   assumes the hand-over timing: read data one cycle after the strobe. */
`timescale 1ns/1ps
module gpio_port_with_pin_sense_test;
  import gpio_pkg::*;
  logic        clk, reset, reg_wr, reg_rd, power_off, detect;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_down;
  logic [31:0] periph_own, periph_out, periph_oe, periph_analog_req, periph_in, analog_pin_tap;
  logic [31:0] ext_val, ext_en, v, got, drv, dir, seed;
  logic [95:0] pin_drive;
  logic [11:0] ops [6];
  logic [1:0]  sc;
  int          n_mismatch, checked, cycles, i, k;
  gpio_port dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_off(power_off),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .pin_drive(pin_drive), .periph_own(periph_own),
    .periph_out(periph_out), .periph_oe(periph_oe), .periph_analog_req(periph_analog_req),
    .periph_in(periph_in), .analog_pin_tap(analog_pin_tap), .detect(detect));
  pin_world world (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
    .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down), .ext_val(ext_val), .ext_en(ext_en));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far above the roughly 560 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk32(input logic [31:0] exp, input logic [31:0] act);
    checked++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t word exp %h got %h", $time, exp, act);
    end
  endtask : chk32
  task automatic chk1(input logic exp, input logic act);
    checked++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t bit exp %b got %b", $time, exp, act);
    end
  endtask : chk1
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  function automatic logic [31:0] upd(int op, logic [31:0] old, logic [31:0] d);
    return (op == 0) ? d : (op == 1) ? (old | d) : (old & ~d);
  endfunction : upd
  function automatic logic hit(logic [1:0] code, logic lev);
    return (code == SENSE_HIGH && lev) || (code == SENSE_LOW && !lev);
  endfunction : hit
  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    {reg_wr, reg_rd, power_off, reg_addr, reg_wdata} = '0;
    {periph_own, periph_out, periph_oe, periph_analog_req, ext_val, ext_en} = '0;
    seed = 32'h14c9;
    ops = '{OFS_DRIVE_LEVEL, OFS_DRIVE_SET, OFS_DRIVE_CLR, OFS_OE_MASK, OFS_OE_SET, OFS_OE_CLR};
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_OE_MASK, got); chk32(OE_RST, got);
    rd(OFS_DRIVE_LEVEL, got); chk32(DRIVE_RST, got);
    rd(OFS_SETUP_LAST, got); chk32(SETUP_RST, got);
    rd(OFS_PIN_LEVEL, got); chk32(32'h0, got);
    rd(12'h600, got); chk32(32'h0, got);
    drv = DRIVE_RST;
    dir = OE_RST;
    // random traffic through every level and direction alias; one write lands in OFF mode
    for (i = 0; i < 36; i++) begin
      k = i % 6;
      v = $random(seed);
      periph_analog_req <= $random(seed);
      power_off <= (i == 31);
      wr(ops[k], v);
      power_off <= 1'b0;
      if (i != 31 && k < 3) drv = upd(k, drv, v);
      if (k >= 3) dir = upd(k - 3, dir, v);
      rd(OFS_DRIVE_LEVEL, got); chk32(drv, got);
      rd(OFS_OE_MASK, got); chk32(dir, got);
      chk32(drv, pin_out);
      chk32(~dir, pin_oe_n);
      rd(OFS_SETUP_FIRST + 12'({v[4:0], 2'h0}), got); chk1(dir[v[4:0]], got[0]);
    end
    // alias reads return the underlying register; an unaligned setup address reads 0
    rd(OFS_DRIVE_SET, got); chk32(drv, got);
    rd(OFS_DRIVE_CLR, got); chk32(drv, got);
    rd(OFS_OE_SET, got); chk32(dir, got);
    rd(OFS_OE_CLR, got); chk32(dir, got);
    rd(OFS_SETUP_FIRST + 12'h2, got); chk32(32'h0, got);
    // every setup word, pull codes limited to the defined ones
    for (i = 0; i < 32; i++) begin
      v = $random(seed);
      if (v[3:2] == 2'h2) v[2] = 1'b1;
      wr(OFS_SETUP_FIRST + 12'(4 * i), v);
      dir[i] = v[0];
      rd(OFS_SETUP_FIRST + 12'(4 * i), got); chk32(v & (SETUP_WMASK | 32'h1), got);
      chk1(v[3:2] == PULL_UP, pin_pull_up[i]);
      chk1(v[3:2] == PULL_DOWN, pin_pull_down[i]);
      chk32({29'h0, v[10:8]}, {29'h0, pin_drive[3 * i +: 3]});
    end
    rd(OFS_OE_MASK, got); chk32(dir, got);
    for (i = 0; i < 32; i++) wr(OFS_SETUP_FIRST + 12'(4 * i), SETUP_RST);
    // pin 3 alone connected; each sense code at both levels, last two in OFF mode
    for (k = 0; k < 6; k++) begin
      sc = (k < 2) ? 2'h0 : (k < 4) ? SENSE_HIGH : SENSE_LOW;
      wr(OFS_SETUP_FIRST + 12'hc, {14'h0, sc, 16'h0});
      power_off <= (k > 3);
      ext_en <= 32'h8;
      ext_val <= {28'h0, k[0], 3'h0};
      repeat (5) @(posedge clk);
      #1 chk1(hit(sc, k[0]), detect);
      chk32({28'h0, k[0], 3'h0}, periph_in);
      rd(OFS_PIN_LEVEL, got); chk32({28'h0, k[0], 3'h0}, got);
    end
    power_off <= 1'b0;
    // the setup word written before OFF mode must survive the trip back to ON
    rd(OFS_SETUP_FIRST + 12'hc, got); chk32({14'h0, SENSE_LOW, 16'h0}, got);
    // a peripheral takes pin 5 over
    periph_own <= 32'h20;
    periph_out <= 32'h20;
    periph_oe <= 32'h20;
    repeat (3) @(posedge clk);
    #1 chk1(1'b1, pin_out[5]);
    chk1(1'b0, pin_oe_n[5]);
    periph_own <= 32'h0;
    tally_and_finish();
  end
endmodule : gpio_port_with_pin_sense_test
